// ### logic/usr_pkg.sv
/*
 * Shared constants and types for the serial receive path (async, sync and SPI).
 * Assumes a single 100 MHz system clock; all pins are synchronised inside the block.
 */
package usr_pkg;

	// ***********************************************
	// operating modes and parity
	// ***********************************************
	localparam int          USR_MODE_W     = 2;
	localparam logic [1:0]  USR_MODE_ASYNC = 2'h0;
	localparam logic [1:0]  USR_MODE_SYNC  = 2'h1;
	localparam logic [1:0]  USR_MODE_SPI   = 2'h3;
	localparam int          USR_PAR_ON_BIT = 1;
	localparam int          USR_PAR_ODD_BIT = 0;

	// ***********************************************
	// character length codes
	// ***********************************************
	localparam logic [2:0]  USR_LEN_5      = 3'h0;
	localparam logic [2:0]  USR_LEN_6      = 3'h1;
	localparam logic [2:0]  USR_LEN_7      = 3'h2;
	localparam logic [2:0]  USR_LEN_8      = 3'h3;
	localparam logic [2:0]  USR_LEN_9      = 3'h7;
	localparam int          USR_MSB_FIRST_BIT = 1;
	localparam logic [3:0]  USR_SPI_BITS   = 4'h8;

	// ***********************************************
	// oversampling: last sample index and vote window
	// ***********************************************
	localparam logic [3:0]  USR_LAST_NORM  = 4'hF;
	localparam logic [3:0]  USR_LAST_DBL   = 4'h7;
	localparam logic [3:0]  USR_VOTE_NORM  = 4'h7;
	localparam logic [3:0]  USR_VOTE_DBL   = 4'h3;
	localparam logic [3:0]  USR_DEC_NORM   = 4'h9;
	localparam logic [3:0]  USR_DEC_DBL    = 4'h5;

	// ***********************************************
	// receive buffer entry layout
	// ***********************************************
	localparam int          USR_DATA_W     = 9;
	localparam int          USR_ENT_FRM    = 9;
	localparam int          USR_ENT_PAR    = 10;
	localparam int          USR_ENTRY_W    = 11;
	localparam int          USR_BUF_DEPTH  = 2;

	typedef enum logic [3:0] {
		USR_ST_IDLE  = 4'h1,
		USR_ST_START = 4'h2,
		USR_ST_DATA  = 4'h4,
		USR_ST_STOP  = 4'h8
	} usr_state_t;

endpackage

// ### logic/usr_fifo_if.sv
/*
 * Valid/ready carrier between the frame engine and the receive buffer.
 * Assumes both ends run on the same clock.
 */
interface usr_fifo_if #(parameter int WIDTH = 11);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport fifo_side (input push_valid, input push_data, input pop_ready,
		output push_ready, output pop_valid, output pop_data);
	modport user_side (output push_valid, output push_data, output pop_ready,
		input push_ready, input pop_valid, input pop_data);
endinterface

// ### logic/usr_rx_fifo.sv
/*
 * Small synchronous FIFO with flush, used as the receive buffer.
 * Assumes one clock; flush empties it in one edge and wins over push.
 */
module usr_rx_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 2
) (
	input  wire logic    clk,
	input  wire logic    rst_b,
	input  wire logic    flush,
	usr_fifo_if.fifo_side f
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             do_push;
	logic             do_pop;

	assign f.push_ready = (count_ff != (AW+1)'(DEPTH));
	assign f.pop_valid  = (count_ff != '0);
	assign f.pop_data   = mem[rd_ptr_ff];
	assign do_push      = f.push_valid & f.push_ready & ~flush;
	assign do_pop       = f.pop_ready & f.pop_valid & ~flush;

	always_ff @(posedge clk) begin
		if (do_push)
			mem[wr_ptr_ff] <= f.push_data;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else if (flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (do_push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			if (do_pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	chk_fifo_full_refuse: assert property (@(posedge clk) disable iff (!rst_b)
		(count_ff == (AW+1)'(DEPTH)) && !do_pop && !flush |=> count_ff == (AW+1)'(DEPTH))
		else $error("fifo count changed while full without pop");
endmodule

// ### logic/usr_rx.sv
/*
 * Receive path of a USART: async oversampled frames, sync frames on a serial clock, SPI master/slave.
 * Assumes all pins come from outside the clock domain; register access is by plain ports.
 */
module usr_rx (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_b,
	input  wire logic                          receiver_enable,
	input  wire logic [usr_pkg::USR_MODE_W-1:0] op_mode_sel,
	input  wire logic [2:0]                    char_length_sel,
	input  wire logic [1:0]                    parity_mode_sel,
	input  wire logic                          double_speed_sel,
	input  wire logic                          master_sel,
	input  wire logic                          clock_polarity_sel,
	input  wire logic                          clock_phase_sel,
	input  wire logic                          ss_output_en,
	input  wire logic                          master_ss_req,
	input  wire logic [7:0]                    baud_div,
	input  wire logic                          rx_complete_irq_en,
	input  wire logic                          global_irq_en,
	input  wire logic                          rd_data,
	input  wire logic                          serial_in_pin,
	input  wire logic                          serial_clock_pin,
	input  wire logic                          ss_in_b,
	output logic                               ss_out_b,
	output logic                               ss_oe,
	output logic                               rx_pin_owned,
	output logic [7:0]                         data_buffer_reg,
	output logic                               ninth_rx_bit,
	output logic                               framing_err_flag,
	output logic                               overrun_flag,
	output logic                               parity_err_flag,
	output logic                               rx_complete_flag,
	output logic                               rx_irq_req
);
	import usr_pkg::*;

	// ***********************************************
	// pin synchronisers and edge detection
	// ***********************************************
	logic       rxd_m_ff, rxd_s_ff, sclk_m_ff, sclk_s_ff, sclk_d_ff, ss_m_ff, ss_s_ff;
	logic       mode_async, mode_sync, mode_spi, spi_act, parity_on, msb_first;
	logic       sclk_rise, sclk_fall, samp_edge;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_m_ff <= 1'b1;
			rxd_s_ff <= 1'b1;
			sclk_m_ff <= 1'b0;
			sclk_s_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			ss_m_ff  <= 1'b1;
			ss_s_ff  <= 1'b1;
		end else begin
			rxd_m_ff <= serial_in_pin;
			rxd_s_ff <= rxd_m_ff;
			sclk_m_ff <= serial_clock_pin;
			sclk_s_ff <= sclk_m_ff;
			sclk_d_ff <= sclk_s_ff;
			ss_m_ff  <= ss_in_b;
			ss_s_ff  <= ss_m_ff;
		end
	end

	assign mode_async = (op_mode_sel == USR_MODE_ASYNC);
	assign mode_sync  = (op_mode_sel == USR_MODE_SYNC);
	assign mode_spi   = (op_mode_sel == USR_MODE_SPI);
	assign parity_on  = parity_mode_sel[USR_PAR_ON_BIT] & ~mode_spi;
	assign msb_first  = char_length_sel[USR_MSB_FIRST_BIT];
	// slave listens only while its select is low
	assign spi_act    = mode_spi & (master_sel | ~ss_s_ff);
	assign sclk_rise  = sclk_s_ff & ~sclk_d_ff;
	assign sclk_fall  = ~sclk_s_ff & sclk_d_ff;

	// spi: leading edge samples at phase 0, trailing at phase 1; sync samples opposite to change
	always_comb begin
		if (mode_spi)
			samp_edge = (clock_polarity_sel ^ clock_phase_sel) ? sclk_fall : sclk_rise;
		else
			samp_edge = clock_polarity_sel ? sclk_rise : sclk_fall;
	end

	// ***********************************************
	// oversampling tick and majority vote
	// ***********************************************
	logic [7:0] tick_cnt_ff;
	logic       tick;
	logic [3:0] cnt_ff;
	logic [1:0] vote_ff;
	logic       rxd_tick_ff;
	logic [3:0] last_idx, vote_idx, dec_idx;
	logic       maj, a_ev, ev, val, fall_seen;
	usr_state_t state_ff;

	assign tick     = (tick_cnt_ff == 8'h00);
	assign last_idx = double_speed_sel ? USR_LAST_DBL : USR_LAST_NORM;
	assign vote_idx = double_speed_sel ? USR_VOTE_DBL : USR_VOTE_NORM;
	assign dec_idx  = double_speed_sel ? USR_DEC_DBL : USR_DEC_NORM;
	assign maj      = (vote_ff[1] & vote_ff[0]) | (vote_ff[1] & rxd_s_ff) | (vote_ff[0] & rxd_s_ff);
	assign a_ev     = tick & (cnt_ff == dec_idx) & (state_ff != USR_ST_IDLE);
	assign fall_seen = tick & rxd_tick_ff & ~rxd_s_ff;
	assign ev       = mode_async ? a_ev : samp_edge;
	assign val      = mode_async ? maj : rxd_s_ff;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			tick_cnt_ff <= 8'h00;
		else if (tick || !receiver_enable)
			tick_cnt_ff <= baud_div;
		else
			tick_cnt_ff <= tick_cnt_ff - 8'h01;
	end

	// the detecting sample is number zero; cnt_ff holds the index of the next sample
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff      <= 4'h0;
			vote_ff     <= 2'h3;
			rxd_tick_ff <= 1'b1;
		end else if (!receiver_enable) begin
			cnt_ff      <= 4'h0;
			vote_ff     <= 2'h3;
			rxd_tick_ff <= 1'b1;
		end else if (tick) begin
			rxd_tick_ff <= rxd_s_ff;
			if (state_ff == USR_ST_IDLE)
				cnt_ff <= fall_seen ? 4'h1 : 4'h0;
			else
				cnt_ff <= (cnt_ff == last_idx) ? 4'h0 : cnt_ff + 4'h1;
			if (cnt_ff >= vote_idx && cnt_ff < dec_idx)
				vote_ff <= {vote_ff[0], rxd_s_ff};
		end
	end

	// ***********************************************
	// frame engine
	// ***********************************************
	logic [3:0] idx_ff, dlen, nbits, pos;
	logic [8:0] data_sh_ff, data_with;
	logic       par_ff;
	logic       push_valid_ff;
	logic [USR_ENTRY_W-1:0] push_entry_ff;
	logic       par_err_calc;

	always_comb begin
		case (char_length_sel)
			USR_LEN_5: dlen = 4'h5;
			USR_LEN_6: dlen = 4'h6;
			USR_LEN_7: dlen = 4'h7;
			USR_LEN_8: dlen = 4'h8;
			default:   dlen = 4'h9;
		endcase
		if (mode_spi)
			dlen = USR_SPI_BITS;
		nbits = dlen + 4'(parity_on);
		pos   = (mode_spi && msb_first) ? USR_SPI_BITS - 4'h1 - idx_ff : idx_ff;
		data_with      = data_sh_ff;
		data_with[pos] = val;
	end

	// unused high data bits stay zero, so xor over all nine is the data parity
	assign par_err_calc = parity_on & ((^data_sh_ff) ^ par_ff ^ parity_mode_sel[USR_PAR_ODD_BIT]);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff      <= USR_ST_IDLE;
			idx_ff        <= 4'h0;
			data_sh_ff    <= 9'h000;
			par_ff        <= 1'b0;
			push_valid_ff <= 1'b0;
			push_entry_ff <= '0;
		end else if (!receiver_enable || (mode_spi && !spi_act)) begin
			state_ff      <= USR_ST_IDLE;
			idx_ff        <= 4'h0;
			push_valid_ff <= 1'b0;
		end else begin
			push_valid_ff <= 1'b0;
			case (state_ff)
				USR_ST_IDLE: begin
					if (mode_async && fall_seen) begin
						state_ff <= USR_ST_START;
					end else if (mode_sync && samp_edge && !rxd_s_ff) begin
						state_ff   <= USR_ST_DATA;
						idx_ff     <= 4'h0;
						data_sh_ff <= 9'h000;
					end else if (mode_spi && samp_edge) begin
						state_ff   <= USR_ST_DATA;
						idx_ff     <= 4'h1;
						data_sh_ff <= 9'h000;
						data_sh_ff[pos] <= val;
					end
				end
				USR_ST_START: begin
					if (ev) begin
						// a high majority was noise, not a start bit
						state_ff   <= val ? USR_ST_IDLE : USR_ST_DATA;
						idx_ff     <= 4'h0;
						data_sh_ff <= 9'h000;
					end
				end
				USR_ST_DATA: begin
					if (ev) begin
						if (idx_ff < dlen)
							data_sh_ff[pos] <= val;
						else
							par_ff <= val;
						idx_ff <= idx_ff + 4'h1;
						if (idx_ff == nbits - 4'h1) begin
							if (mode_spi) begin
								state_ff      <= USR_ST_IDLE;
								push_valid_ff <= 1'b1;
								push_entry_ff <= {2'b00, data_with};
							end else begin
								state_ff <= USR_ST_STOP;
							end
						end
					end
				end
				USR_ST_STOP: begin
					if (ev) begin
						// only the first stop bit is looked at; a second one reads as idle line
						state_ff      <= USR_ST_IDLE;
						push_valid_ff <= 1'b1;
						push_entry_ff <= {par_err_calc, ~val, data_sh_ff};
					end
				end
				default: state_ff <= USR_ST_IDLE;
			endcase
		end
	end

	// ***********************************************
	// receive buffer and status outputs
	// ***********************************************
	usr_fifo_if #(.WIDTH(USR_ENTRY_W)) fifo_bus ();
	logic overrun_ff;

	assign fifo_bus.push_valid = push_valid_ff;
	assign fifo_bus.push_data  = push_entry_ff;
	assign fifo_bus.pop_ready  = rd_data & receiver_enable;

	usr_rx_fifo #(
		.WIDTH (USR_ENTRY_W),
		.DEPTH (USR_BUF_DEPTH)
	) u_buf (
		.clk   (sys_clk),
		.rst_b (rst_b),
		.flush (~receiver_enable),
		.f     (fifo_bus)
	);

	// a full buffer refuses the frame; the new set wins over a read in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			overrun_ff <= 1'b0;
		else if (!receiver_enable)
			overrun_ff <= 1'b0;
		else if (push_valid_ff && !fifo_bus.push_ready)
			overrun_ff <= 1'b1;
		else if (rd_data && fifo_bus.pop_valid)
			overrun_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_buffer_reg  <= 8'h00;
			ninth_rx_bit     <= 1'b0;
			framing_err_flag <= 1'b0;
			parity_err_flag  <= 1'b0;
			overrun_flag     <= 1'b0;
			rx_complete_flag <= 1'b0;
			rx_irq_req       <= 1'b0;
		end else begin
			data_buffer_reg  <= fifo_bus.pop_valid ? fifo_bus.pop_data[7:0] : 8'h00;
			ninth_rx_bit     <= fifo_bus.pop_valid & fifo_bus.pop_data[8];
			framing_err_flag <= fifo_bus.pop_valid & fifo_bus.pop_data[USR_ENT_FRM] & ~mode_spi;
			parity_err_flag  <= fifo_bus.pop_valid & fifo_bus.pop_data[USR_ENT_PAR] & parity_on;
			// gate with enable so a disable hides the sticky bit at once
			overrun_flag     <= overrun_ff & receiver_enable & ~mode_spi;
			rx_complete_flag <= receiver_enable & fifo_bus.pop_valid;
			rx_irq_req       <= receiver_enable & fifo_bus.pop_valid & rx_complete_irq_en & global_irq_en;
		end
	end

	// ***********************************************
	// pin ownership and select pin
	// ***********************************************
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_pin_owned <= 1'b0;
			ss_out_b     <= 1'b1;
			ss_oe        <= 1'b0;
		end else begin
			rx_pin_owned <= receiver_enable;
			ss_out_b     <= ~master_ss_req;
			ss_oe        <= mode_spi & master_sel & ss_output_en;
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence seq_stop_seen;
		(state_ff == USR_ST_STOP) && ev && receiver_enable;
	endsequence

	chk_pin_follows_enable: assert property (rx_pin_owned == $past(receiver_enable))
		else $error("pin ownership does not follow enable");
	chk_stop_push_frm: assert property (seq_stop_seen |=> push_valid_ff &&
		push_entry_ff[USR_ENT_FRM] == !$past(val) && state_ff == USR_ST_IDLE)
		else $error("stop bit did not push frame with right framing bit");
	chk_disable_clears_rxc: assert property (!receiver_enable |=> !rx_complete_flag && !overrun_flag)
		else $error("complete flag survives disable");
	chk_irq_gating: assert property (##1 rx_irq_req == (rx_complete_flag && $past(rx_complete_irq_en)
		&& $past(global_irq_en)))
		else $error("interrupt request not gated by flag and enables");
	chk_overrun_sets: assert property (push_valid_ff && !fifo_bus.push_ready && receiver_enable
		&& !mode_spi ##1 !mode_spi |=> overrun_flag)
		else $error("overrun not flagged on full buffer");
	chk_parity_off_zero: assert property ($past(!parity_mode_sel[USR_PAR_ON_BIT]) |-> !parity_err_flag)
		else $error("parity error shown with parity off");
	chk_spi_no_errors: assert property ($past(mode_spi) |-> !framing_err_flag && !parity_err_flag
		&& !overrun_flag)
		else $error("error flag in spi mode");
	chk_start_reject: assert property ((state_ff == USR_ST_START) && ev && val && receiver_enable
		|=> state_ff == USR_ST_IDLE)
		else $error("high start majority not rejected");
	chk_sample_wrap: assert property (tick && receiver_enable && state_ff != USR_ST_IDLE
		&& cnt_ff == last_idx |=> cnt_ff == 4'h0)
		else $error("oversample count does not wrap at rate");
endmodule

// ### tb/usr_peer_model.sv
/*
 * Far-side peer of the receive path: async transmitter, sync transmitter and SPI master on the pins.
 * Assumes the bench calls one task at a time; times are in ns and pins idle as on the real line.
 */
module usr_peer_model (
	output logic serial_in_pin,
	output logic serial_clock_pin,
	output logic ss_in_b
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		serial_in_pin    = 1'b1;
		serial_clock_pin = 1'b0;
		ss_in_b          = 1'b1;
	end

	// ***********************************************
	// async frame: bit 0 is the start bit
	// ***********************************************
	task automatic send_async(input logic [15:0] bits, input int n, input int bit_ns);
		for (int i = 0; i < n; i++) begin
			serial_in_pin = bits[i];
			#(bit_ns);
		end
		serial_in_pin = 1'b1;
		// keeps back-to-back frames from writing the pin twice in one step
		#1;
	endtask

	// ***********************************************
	// clocked frame, 125 ns per bit; clock stands still outside frames
	// ***********************************************
	task automatic send_clocked(input logic [15:0] bits, input int n, input logic pol, input logic pha,
		input logic use_ss);
		serial_clock_pin = pol;
		#125;
		if (use_ss)
			ss_in_b = 1'b0;
		#125;
		for (int i = 0; i < n; i++) begin
			if (!pha)
				serial_in_pin = bits[i];
			#62;
			serial_clock_pin = ~pol;
			#20;
			if (pha)
				serial_in_pin = bits[i];
			#43;
			serial_clock_pin = pol;
		end
		#62;
		// released line shows no stale value
		serial_in_pin = ~serial_in_pin;
		ss_in_b = 1'b1;
		#125;
	endtask
endmodule

// ### tb/usr_rx_tb.sv
/*
 * Self-checking bench of the receive path: table of async frames, then hand-written edge cases.
 * Assumes the peer model owns the serial pins; baud_div fixed so one oversample tick is 20 ns.
 */
`define CHK(what, want, got) \
	begin \
		n_tests++; \
		if ((got) !== (want)) begin \
			fail_count++; \
			$display("unexpected %s: expected %0h, seen %0h", what, want, got); \
		end \
	end

module usr_rx_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import usr_pkg::*;

	typedef struct packed {
		logic [2:0] len;
		logic [1:0] par;
		logic       dbl;
		logic [8:0] data;
		logic       stop_ok;
		logic       bad_par;
	} usr_tb_row_t;

	localparam int TICK_NS = 20;

	logic                  sys_clk, rst_b, receiver_enable, double_speed_sel, master_sel;
	logic [USR_MODE_W-1:0] op_mode_sel;
	logic [2:0]            char_length_sel;
	logic [1:0]            parity_mode_sel;
	logic                  clock_polarity_sel, clock_phase_sel, ss_output_en, master_ss_req;
	logic [7:0]            baud_div;
	logic                  rx_complete_irq_en, global_irq_en, rd_data;
	logic                  serial_in_pin, serial_clock_pin, ss_in_b, ss_out_b, ss_oe, rx_pin_owned;
	logic [7:0]            data_buffer_reg;
	logic                  ninth_rx_bit, framing_err_flag, overrun_flag, parity_err_flag;
	logic                  rx_complete_flag, rx_irq_req;
	int                    fail_count, n_tests, n;
	logic [15:0]           bits;
	logic [8:0]            want;
	logic [7:0]            d;
	usr_tb_row_t           rows [7];

	usr_rx u_usr_rx (.sys_clk(sys_clk), .rst_b(rst_b), .receiver_enable(receiver_enable),
		.op_mode_sel(op_mode_sel), .char_length_sel(char_length_sel), .parity_mode_sel(parity_mode_sel),
		.double_speed_sel(double_speed_sel), .master_sel(master_sel), .clock_polarity_sel(clock_polarity_sel),
		.clock_phase_sel(clock_phase_sel), .ss_output_en(ss_output_en), .master_ss_req(master_ss_req),
		.baud_div(baud_div), .rx_complete_irq_en(rx_complete_irq_en), .global_irq_en(global_irq_en),
		.rd_data(rd_data), .serial_in_pin(serial_in_pin), .serial_clock_pin(serial_clock_pin),
		.ss_in_b(ss_in_b), .ss_out_b(ss_out_b), .ss_oe(ss_oe), .rx_pin_owned(rx_pin_owned),
		.data_buffer_reg(data_buffer_reg), .ninth_rx_bit(ninth_rx_bit),
		.framing_err_flag(framing_err_flag), .overrun_flag(overrun_flag),
		.parity_err_flag(parity_err_flag), .rx_complete_flag(rx_complete_flag), .rx_irq_req(rx_irq_req));

	usr_peer_model u_usr_peer_model (.serial_in_pin(serial_in_pin), .serial_clock_pin(serial_clock_pin),
		.ss_in_b(ss_in_b));

	// ***********************************************
	// helpers
	// ***********************************************
	function automatic int build(input usr_tb_row_t r, output logic [15:0] b, output logic [8:0] w);
		int nb;
		nb = (r.len <= USR_LEN_8) ? int'(r.len) + 5 : 9;
		w = r.data & ~(9'h1FF << nb);
		b = 16'h0;
		for (int i = 0; i < nb; i++)
			b[i+1] = w[i];
		if (r.par[USR_PAR_ON_BIT]) begin
			b[nb+1] = ^w ^ r.par[USR_PAR_ODD_BIT] ^ r.bad_par;
			nb++;
		end
		b[nb+1] = r.stop_ok;
		return nb + 2;
	endfunction

	task automatic wait_flag(input logic v);
		int k;
		k = 0;
		while (rx_complete_flag !== v && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
		`CHK("rx_complete_flag", v, rx_complete_flag);
	endtask

	task automatic read_one();
		@(negedge sys_clk);
		rd_data = 1'b1;
		@(negedge sys_clk);
		rd_data = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask

	task automatic stop_test();
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// about 40 us of traffic; anything far beyond is a hang
	initial begin
		#400us;
		fail_count++;
		stop_test();
	end

	// ***********************************************
	// main sequence
	// ***********************************************
	initial begin
		{rst_b, receiver_enable, double_speed_sel, master_sel, clock_polarity_sel, clock_phase_sel} = 6'h0;
		{ss_output_en, master_ss_req, rx_complete_irq_en, global_irq_en, rd_data} = 5'h0;
		op_mode_sel = USR_MODE_ASYNC;
		char_length_sel = USR_LEN_8;
		parity_mode_sel = 2'h0;
		baud_div = 8'h01;
		fail_count = 0;
		n_tests = 0;
		rows = '{'{USR_LEN_8, 2'h0, 1'b0, 9'h0A5, 1'b1, 1'b0}, '{USR_LEN_5, 2'h2, 1'b0, 9'h013, 1'b1, 1'b0},
			'{USR_LEN_9, 2'h3, 1'b1, 9'h1C3, 1'b1, 1'b0}, '{USR_LEN_7, 2'h2, 1'b0, 9'h05A, 1'b1, 1'b1},
			'{USR_LEN_6, 2'h0, 1'b1, 9'h02D, 1'b0, 1'b0}, '{USR_LEN_8, 2'h1, 1'b0, 9'h0F0, 1'b1, 1'b0},
			'{USR_LEN_8, 2'h3, 1'b1, 9'h081, 1'b1, 1'b1}};
		repeat (2) @(negedge sys_clk);
		`CHK("ss_out_b in reset", 1'b1, ss_out_b);
		`CHK("flag in reset", 1'b0, rx_complete_flag);
		rst_b = 1'b1;
		receiver_enable = 1'b1;
		repeat (3) @(negedge sys_clk);
		`CHK("rx_pin_owned", 1'b1, rx_pin_owned);

		foreach (rows[i]) begin
			char_length_sel = rows[i].len;
			parity_mode_sel = rows[i].par;
			double_speed_sel = rows[i].dbl;
			rx_complete_irq_en = i[0];
			global_irq_en = i[1];
			n = build(rows[i], bits, want);
			u_usr_peer_model.send_async(bits, n, (rows[i].dbl ? 8 : 16) * TICK_NS);
			wait_flag(1'b1);
			`CHK("data", want[7:0], data_buffer_reg);
			`CHK("ninth bit", want[8], ninth_rx_bit);
			`CHK("framing", ~rows[i].stop_ok, framing_err_flag);
			`CHK("parity", rows[i].par[1] & rows[i].bad_par, parity_err_flag);
			`CHK("irq", 1'(i[0] & i[1]), rx_irq_req);
			read_one();
			`CHK("flag after read", 1'b0, rx_complete_flag);
		end

		// three frames into a two-entry buffer
		{char_length_sel, parity_mode_sel, double_speed_sel} = {USR_LEN_8, 2'h0, 1'b0};
		for (int k = 1; k <= 3; k++)
			u_usr_peer_model.send_async({6'h3F, 1'b1, 8'(k * 17), 1'b0}, 10, 16 * TICK_NS);
		repeat (4) @(negedge sys_clk);
		`CHK("overrun set", 1'b1, overrun_flag);
		`CHK("first entry", 8'h11, data_buffer_reg);
		read_one();
		`CHK("second entry", 8'h22, data_buffer_reg);
		`CHK("overrun cleared", 1'b0, overrun_flag);
		read_one();
		wait_flag(1'b0);

		// disable flushes a full entry
		u_usr_peer_model.send_async({6'h3F, 1'b1, 8'h44, 1'b0}, 10, 16 * TICK_NS);
		wait_flag(1'b1);
		receiver_enable = 1'b0;
		repeat (3) @(negedge sys_clk);
		`CHK("flush flag", 1'b0, rx_complete_flag);
		`CHK("flush data", 8'h00, data_buffer_reg);
		`CHK("pin released", 1'b0, rx_pin_owned);
		receiver_enable = 1'b1;
		// disable in mid-frame: the frame must be dropped
		fork
			u_usr_peer_model.send_async({6'h3F, 1'b1, 8'hFF, 1'b0}, 10, 16 * TICK_NS);
			begin
				#1000;
				receiver_enable = 1'b0;
				#200;
				receiver_enable = 1'b1;
			end
		join
		// low pulse of four ticks, gone before the vote window opens
		u_usr_peer_model.send_async(16'h0, 1, 4 * TICK_NS);
		repeat (60) @(negedge sys_clk);
		`CHK("no frame", 1'b0, rx_complete_flag);

		// synchronous slave frame, sampled on falling clock
		op_mode_sel = USR_MODE_SYNC;
		parity_mode_sel = 2'h2;
		n = build('{USR_LEN_8, 2'h2, 1'b0, 9'h096, 1'b1, 1'b0}, bits, want);
		u_usr_peer_model.send_clocked(bits, n, 1'b0, 1'b1, 1'b0);
		wait_flag(1'b1);
		`CHK("sync data", 8'h96, data_buffer_reg);
		read_one();

		// SPI slave in all four clock modes, then MSB first
		op_mode_sel = USR_MODE_SPI;
		parity_mode_sel = 2'h3;
		for (int m = 0; m < 5; m++) begin
			d = 8'hC3 ^ 8'(m * 37);
			char_length_sel = (m == 4) ? 3'h2 : 3'h0;
			{clock_polarity_sel, clock_phase_sel} = 2'(m);
			for (int b = 0; b < 8; b++)
				bits[b] = (m == 4) ? d[7-b] : d[b];
			u_usr_peer_model.send_clocked(bits, 8, clock_polarity_sel, clock_phase_sel, 1'b1);
			wait_flag(1'b1);
			`CHK("spi data", d, data_buffer_reg);
			`CHK("spi flags", 3'h0, {framing_err_flag, parity_err_flag, overrun_flag});
			read_one();
		end

		// select pin as master output
		`CHK("slave ss_oe", 1'b0, ss_oe);
		{master_sel, ss_output_en, master_ss_req} = 3'h7;
		repeat (3) @(negedge sys_clk);
		`CHK("master ss_oe", 1'b1, ss_oe);
		`CHK("master ss_out_b", 1'b0, ss_out_b);
		ss_output_en = 1'b0;
		repeat (3) @(negedge sys_clk);
		`CHK("ss_oe off", 1'b0, ss_oe);
		stop_test();
	end
endmodule
